// ===== logic/pie_pkg.sv
`default_nettype none
package pie_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int PRIO_COUNT = 3;

  // Register offsets on the internal register port.
  localparam logic [3:0] OFF_ENABLE_SECOND = 4'h0;
  localparam logic [3:0] OFF_PRIO_FIRST = 4'h1;
  localparam logic [3:0] OFF_PRIO_SECOND = 4'h2;
  localparam logic [3:0] OFF_PRIO_THIRD = 4'h3;
  localparam logic [3:0] OFF_CONTROL = 4'h4;
  localparam logic [3:0] OFF_PENDING = 4'h5;
  localparam logic [3:0] OFF_FLAGS = 4'h6;

  // Bit positions in the second enable register.
  localparam int BIT_ENHANCED_CAPTURE = 0;
  localparam int BIT_TIMER_THREE = 1;
  localparam int BIT_LOW_VOLTAGE = 2;
  localparam int BIT_BUS_COLLISION = 3;
  localparam int BIT_EEPROM_WRITE = 4;
  localparam int BIT_COMPARATOR = 6;

  // Bit position of the global priority enable in the control register.
  localparam int BIT_GLOBAL_PRIORITY = 0;

  // Values after reset.
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] PRIO_RESET = 8'hFF;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Writable bits of the second enable register per package variant, and of the control register.
  localparam logic [7:0] ENABLE_MASK_FULL = 8'h5F;
  localparam logic [7:0] ENABLE_MASK_SMALL = 8'h1E;
  localparam logic [7:0] CONTROL_MASK = 8'h01;
endpackage
`default_nettype wire

// ===== logic/pie_prio_if.sv
`default_nettype none
interface pie_prio_if;
  logic [pie_pkg::PRIO_COUNT-1:0] wr_sel;
  logic [7:0] wdata;
  logic global_priority_enable;
  logic [pie_pkg::PRIO_COUNT-1:0][7:0] prio_raw;
  logic [pie_pkg::PRIO_COUNT-1:0][7:0] prio_eff;

  modport ctrl (
    output wr_sel,
    output wdata,
    output global_priority_enable,
    input prio_raw,
    input prio_eff
  );

  modport bank (
    input wr_sel,
    input wdata,
    input global_priority_enable,
    output prio_raw,
    output prio_eff
  );
endinterface
`default_nettype wire

// ===== logic/pie_prio_bank.sv
`default_nettype none
module pie_prio_bank (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Link to the enable bank.
  pie_prio_if.bank link
);
  // One storage register per priority bank, all kept apart from the enables.
  genvar i;
  generate
    for (i = 0; i < pie_pkg::PRIO_COUNT; i++) begin : g_prio
      logic [7:0] prio_q;
      always_ff @(posedge clock) begin
        if (!rstn) begin
          prio_q <= pie_pkg::PRIO_RESET;
        end else if (link.wr_sel[i]) begin
          prio_q <= link.wdata;
        end
      end
      assign link.prio_raw[i] = prio_q;
      // With priority off every source is treated as one level.
      assign link.prio_eff[i] = link.global_priority_enable ? prio_q : 8'hFF;
    end
  endgenerate
endmodule
`default_nettype wire

// ===== logic/pie_enable_bank.sv
`default_nettype none
module pie_enable_bank #(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Register port.
  input wire logic [pie_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pie_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pie_pkg::DATA_W-1:0] reg_rdata,
  // Peripheral flags of the second bank.
  input wire logic [7:0] source_flags,
  // Requests of the second bank toward the core.
  output logic irq_high,
  output logic irq_low,
  output logic [7:0] pending,
  // Settings seen by the other banks.
  output logic [7:0] enable_second,
  output logic global_priority_enable,
  output logic [7:0] prio_eff_first,
  output logic [7:0] prio_eff_second,
  output logic [7:0] prio_eff_third
);
  localparam logic [7:0] EN_MASK = SMALL_PACKAGE ? pie_pkg::ENABLE_MASK_SMALL
                                                 : pie_pkg::ENABLE_MASK_FULL;

  pie_prio_if prio_link ();

  logic [7:0] enable_q;
  logic [7:0] control_q;
  logic [7:0] pending_d;
  logic [7:0] pending_q;
  logic irq_high_q;
  logic irq_low_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] eff_first_q;
  logic [7:0] eff_second_q;
  logic [7:0] eff_third_q;
  logic [7:0] prio_second;

  // Enable register; unimplemented bits never take a one.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      enable_q <= pie_pkg::ENABLE_RESET;
    end else if (reg_wr && reg_addr == pie_pkg::OFF_ENABLE_SECOND) begin
      enable_q <= reg_wdata & EN_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      control_q <= pie_pkg::CONTROL_RESET;
    end else if (reg_wr && reg_addr == pie_pkg::OFF_CONTROL) begin
      control_q <= reg_wdata & pie_pkg::CONTROL_MASK;
    end
  end

  // Priority storage lives in the bank; the decode stays here.
  assign prio_link.wr_sel[0] = reg_wr && reg_addr == pie_pkg::OFF_PRIO_FIRST;
  assign prio_link.wr_sel[1] = reg_wr && reg_addr == pie_pkg::OFF_PRIO_SECOND;
  assign prio_link.wr_sel[2] = reg_wr && reg_addr == pie_pkg::OFF_PRIO_THIRD;
  assign prio_link.wdata = reg_wdata;
  assign prio_link.global_priority_enable = control_q[pie_pkg::BIT_GLOBAL_PRIORITY];

  pie_prio_bank u_prio (
    .clock(clock),
    .rstn(rstn),
    .link(prio_link.bank)
  );

  // Per-source gating of the flags by their enables.
  genvar s;
  generate
    for (s = 0; s < 8; s++) begin : g_src
      assign pending_d[s] = source_flags[s] & enable_q[s] & EN_MASK[s];
    end
  endgenerate

  assign prio_second = prio_link.prio_eff[1];

  always_ff @(posedge clock) begin
    if (!rstn) begin
      pending_q <= 8'h00;
      irq_high_q <= 1'b0;
      irq_low_q <= 1'b0;
    end else begin
      pending_q <= pending_d;
      irq_high_q <= |(pending_d & prio_second);
      irq_low_q <= |(pending_d & ~prio_second);
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      eff_first_q <= pie_pkg::PRIO_RESET;
      eff_second_q <= pie_pkg::PRIO_RESET;
      eff_third_q <= pie_pkg::PRIO_RESET;
    end else begin
      eff_first_q <= prio_link.prio_eff[0];
      eff_second_q <= prio_link.prio_eff[1];
      eff_third_q <= prio_link.prio_eff[2];
    end
  end

  // Read multiplexer; unmapped offsets read zero.
  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr)
      pie_pkg::OFF_ENABLE_SECOND: rdata_d = enable_q & EN_MASK;
      pie_pkg::OFF_PRIO_FIRST: rdata_d = prio_link.prio_raw[0];
      pie_pkg::OFF_PRIO_SECOND: rdata_d = prio_link.prio_raw[1];
      pie_pkg::OFF_PRIO_THIRD: rdata_d = prio_link.prio_raw[2];
      pie_pkg::OFF_CONTROL: rdata_d = control_q;
      pie_pkg::OFF_PENDING: rdata_d = pending_q;
      pie_pkg::OFF_FLAGS: rdata_d = source_flags;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq_high = irq_high_q;
  assign irq_low = irq_low_q;
  assign pending = pending_q;
  assign enable_second = enable_q;
  assign global_priority_enable = control_q[pie_pkg::BIT_GLOBAL_PRIORITY];
  assign prio_eff_first = eff_first_q;
  assign prio_eff_second = eff_second_q;
  assign prio_eff_third = eff_third_q;
endmodule
`default_nettype wire

// ===== sim/pie_enable_bank_asserts.sv
`default_nettype none
module pie_enable_bank_asserts #(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Requests and settings.
  input wire logic [7:0] source_flags,
  input wire logic irq_low,
  input wire logic [7:0] pending,
  input wire logic [7:0] enable_second,
  input wire logic global_priority_enable,
  input wire logic [7:0] prio_eff_third
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  chk_timer_gate: assert property ($past(rstn) |->
    pending[1] == $past(source_flags[1] && enable_second[1])) else $error("timer gate");
  chk_small_unimpl: assert property (SMALL_PACKAGE |->
    ((enable_second | pending) & 8'h41) == 8'h00) else $error("small bits set");
  chk_reserved_zero: assert property (
    ((enable_second | pending) & 8'hA0) == 8'h00) else $error("reserved bits set");
  chk_reset_clear: assert property ($rose(rstn) |-> enable_second == 8'h00)
    else $error("enable not cleared");
  chk_read_enable: assert property (reg_rd && reg_addr == 4'h0 |=>
    reg_rdata == $past(enable_second)) else $error("enable read wrong");
  chk_prio_bypass: assert property ($past(rstn) && !$past(global_priority_enable) |->
    prio_eff_third == 8'hFF) else $error("priority not bypassed");
  chk_low_silent: assert property (!global_priority_enable ##1 !global_priority_enable |=>
    !irq_low) else $error("low request while priority off");
  chk_prio_third: assert property (
    reg_wr && reg_addr == 4'h3 ##1 global_priority_enable |=>
    prio_eff_third == $past(reg_wdata, 2)) else $error("third priority wrong");
endmodule
bind pie_enable_bank pie_enable_bank_asserts #(.SMALL_PACKAGE(SMALL_PACKAGE))
  pie_enable_bank_asserts_inst (.clock, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .source_flags, .irq_low, .pending, .enable_second, .global_priority_enable,
  .prio_eff_third);
`default_nettype wire

// ===== sim/pie_enable_bank_tb_top.sv
`default_nettype none
`define CHK(a, b) begin \
  check_count++; \
  if ((a) !== (b)) begin \
    bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); \
  end \
end
module pie_enable_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [3:0] k;
    logic [3:0] a;
    logic [7:0] d;
    logic [7:0] f;
    logic [7:0] e;
    logic [7:0] p;
  } pie_row_t;
  // Fields: kind (1 write, 2 read), offset, data, flags, read data, pending.
  // Pending follows the enable one cycle late, so a write row still sees the old enable.
  localparam pie_row_t ROWS [14] = '{40'h2_0_00_00_00_00, 40'h1_0_FF_02_00_00,
    40'h2_0_00_FF_5F_5F, 40'h1_0_A0_FF_00_5F, 40'h2_0_00_FF_00_00, 40'h1_0_41_FF_00_00,
    40'h2_0_00_FF_41_41, 40'h1_F_FF_00_00_00, 40'h2_F_00_00_00_00, 40'h2_1_00_00_FF_00,
    40'h1_3_5A_00_00_00, 40'h2_3_00_00_5A_00, 40'h1_5_FF_00_00_00, 40'h2_0_00_00_41_00};
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] source_flags = 8'h00;
  wire [1:0][7:0] rdata;
  wire [1:0][7:0] pending;
  wire [1:0][7:0] enable_second;
  wire [1:0][7:0] prio_first;
  wire [1:0][7:0] prio_second;
  wire [1:0][7:0] prio_third;
  wire [1:0] global_priority_enable;
  wire [1:0] irq_high;
  wire [1:0] irq_low;
  pie_row_t cur = 40'h0;
  pie_row_t prev = 40'h0;
  int bad_count = 0;
  int check_count = 0;
  for (genvar g = 0; g < 2; g++) begin : gen_pkg
    pie_enable_bank #(.SMALL_PACKAGE(g == 1)) pie_enable_bank_inst (.clock, .rstn, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(rdata[g]), .source_flags,
      .irq_high(irq_high[g]), .irq_low(irq_low[g]), .pending(pending[g]),
      .enable_second(enable_second[g]), .global_priority_enable(global_priority_enable[g]),
      .prio_eff_first(prio_first[g]), .prio_eff_second(prio_second[g]),
      .prio_eff_third(prio_third[g]));
  end
  initial forever #5 clock = ~clock;
  task automatic op(input pie_row_t r);
    reg_wr <= r.k[0];
    reg_rd <= r.k[1];
    reg_addr <= r.a;
    reg_wdata <= r.d;
    source_flags <= r.f;
    cur <= r;
    @(posedge clock);
  endtask
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Read data and pending of each operation are judged one cycle after it.
  always @(negedge clock) begin
    for (int g = 0; g < 2; g++) begin
      `CHK(rdata[g], (g == 1 && prev.a == 4'h0) ? prev.e & 8'hBE : prev.e)
      `CHK(pending[g], g == 1 ? prev.p & 8'hBE : prev.p)
    end
    prev <= cur;
  end
  initial begin
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    foreach (ROWS[i]) op(ROWS[i]);
    $display("Table test done");
    op(40'h1_0_02_02_00_00);
    repeat (2) op(40'h0_0_00_02_00_02);
    @(negedge clock);
    for (int g = 0; g < 2; g++) begin
      `CHK(irq_high[g], 1'b1)
      `CHK(irq_low[g], 1'b0)
      `CHK(prio_third[g], 8'hFF)
    end
    @(posedge clock);
    op(40'h1_4_01_02_00_02);
    op(40'h1_3_0F_02_00_02);
    repeat (2) op(40'h0_0_00_02_00_02);
    @(negedge clock);
    for (int g = 0; g < 2; g++) `CHK(prio_third[g], 8'h0F)
    $display("Priority test done");
    @(posedge clock);
    // Second priority register cleared with priority on: the source must report low.
    op(40'h1_2_00_02_00_02);
    repeat (2) op(40'h0_0_00_02_00_02);
    @(negedge clock);
    for (int g = 0; g < 2; g++) begin
      `CHK(irq_low[g], 1'b1)
      `CHK(irq_high[g], 1'b0)
      `CHK(prio_second[g], 8'h00)
      `CHK(prio_first[g], 8'hFF)
      `CHK(global_priority_enable[g], 1'b1)
      `CHK(enable_second[g], 8'h02)
    end
    $display("Low priority test done");
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) op(40'h0);
    rstn <= 1'b1;
    op(40'h2_0_00_00_00_00);
    op(40'h2_3_00_00_FF_00);
    repeat (2) op(40'h0);
    @(negedge clock);
    for (int g = 0; g < 2; g++) begin
      `CHK(irq_low[g], 1'b0)
      `CHK(prio_second[g], 8'hFF)
      `CHK(global_priority_enable[g], 1'b0)
      `CHK(enable_second[g], 8'h00)
    end
    $display("Reset test done");
    print_verdict();
  end
endmodule
`default_nettype wire
